// ==== logic/dac_latch_pkg.sv ====
// constants and types shared by the converter front end
package dac_latch_pkg;
  localparam int unsigned SAMPLE_W      = 12;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam logic [11:0] CODE_ZERO     = 12'h000;
  localparam logic [11:0] CODE_MID      = 12'h800;
  localparam logic [11:0] CODE_FULL     = 12'hfff;
  localparam logic [12:0] CURRENT_FULL  = 13'h0fff;
  localparam logic        SLEEP_DEFAULT = 1'b0;
  localparam logic        REF_INTERNAL  = 1'b0;
  localparam logic        REF_EXTERNAL  = 1'b1;
  // power mode state, one-hot
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b01,
    MODE_SLEEP = 2'b10
  } power_mode_t;
endpackage

// ==== logic/sample_stream_if.sv ====
// valid/ready carrier for sample words between the front end modules
`timescale 1ns/1ps
interface sample_stream_if #(parameter int unsigned WIDTH = 12);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// ==== logic/sample_fifo.sv ====
// flip-flop fifo holding sample words ahead of the output latch
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // write and read sides
  sample_stream_if.sink   wr,
  sample_stream_if.source rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    wptr_next;
  logic [AW-1:0]    rptr_reg;
  logic [AW-1:0]    rptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign wr.ready = (count_reg != (AW+1)'(DEPTH));
  assign rd.valid = (count_reg != '0);
  assign rd.data  = mem_reg[rptr_reg];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    count_next = count_reg;
    if (push) begin
      wptr_next = (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      count_reg <= count_next;
    end
  end

  // storage carries no reset; only pointers and count need a defined value
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= wr.data;
    end
  end

  fifo_no_overflow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (count_reg <= (AW+1)'(DEPTH)))
    else $error("fifo accepts a word while full");
endmodule

// ==== logic/dac_input_latch_control.sv ====
// digital front end of a 12-bit current-output converter
//
// How it works
// - sample word is 12-bit straight binary, bit 0 lsb, bit 11 msb
// - parallel word captured into master register on each rising edge (here only in run mode, from a non-empty fifo)
// - captured word reaches output at the following falling edge (output_code_o; the currents follow at the next rising edge)
// - sleep pin high enters low-current power-down; low runs normally
// - unconnected sleep pin is pulled low, so normal operation by default
// - reference select low uses on-chip bandgap for full-scale current
// - reference select high disables bandgap; reference pin is an input
// - all ones full current to true output, zeros to complement, mid split
//
// the conversion clock is the sys_clk_i domain; the falling-edge slave stage is
// modelled as a second register phase inside the same domain: the master is
// loaded on one system edge and the slave on the next enabled edge, driven by
// a one-cycle enable from a divider that splits each conversion period in two.
`timescale 1ns/1ps
module dac_input_latch_control
  import dac_latch_pkg::*;
#(
  parameter int unsigned WIDTH = SAMPLE_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // sample stream from the source
  input  wire logic [WIDTH-1:0] sample_data_i,
  input  wire logic             sample_valid_i,
  output logic                  sample_ready_o,
  // static pins
  input  wire logic             sleep_request_pin_i,
  input  wire logic             sleep_pin_driven_i,
  input  wire logic             ref_select_i,
  // analog side controls
  output logic [WIDTH-1:0]      output_code_o,
  output logic [WIDTH:0]        true_current_output_o,
  output logic [WIDTH:0]        complement_current_o,
  output logic                  output_update_o,
  output logic                  sleep_active_o,
  output logic                  bandgap_enable_o,
  output logic                  reference_voltage_pin_is_input_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic       sleep_s1_reg;
  logic       sleep_s2_reg;
  logic       driven_s1_reg;
  logic       driven_s2_reg;
  logic       ref_s1_reg;
  logic       ref_s2_reg;
  logic       sleep_level;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sleep_s1_reg  <= 1'b0;
      sleep_s2_reg  <= 1'b0;
      driven_s1_reg <= 1'b0;
      driven_s2_reg <= 1'b0;
      ref_s1_reg    <= 1'b0;
      ref_s2_reg    <= 1'b0;
    end else begin
      sleep_s1_reg  <= sleep_request_pin_i;
      sleep_s2_reg  <= sleep_s1_reg;
      driven_s1_reg <= sleep_pin_driven_i;
      driven_s2_reg <= driven_s1_reg;
      ref_s1_reg    <= ref_select_i;
      ref_s2_reg    <= ref_s1_reg;
    end
  end

  // an undriven sleep pin reads as low, like the internal pull-down
  assign sleep_level = driven_s2_reg ? sleep_s2_reg : SLEEP_DEFAULT;

  ////////////////////////////////////////////////////////////////////////////
  // sample fifo
  sample_stream_if #(.WIDTH(WIDTH)) in_bus ();
  sample_stream_if #(.WIDTH(WIDTH)) out_bus ();

  assign in_bus.data    = sample_data_i;
  assign in_bus.valid   = sample_valid_i;

  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr        (in_bus.sink),
    .rd        (out_bus.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase divider: rise phase loads master, fall phase loads slave
  logic       phase_reg;
  logic       phase_next;
  logic       rise_en;
  logic       fall_en;

  assign rise_en = !phase_reg;
  assign fall_en = phase_reg;

  always_comb begin
    phase_next = !phase_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode
  power_mode_t mode_reg;
  power_mode_t mode_next;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN: begin
        if (sleep_level) begin
          mode_next = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!sleep_level) begin
          mode_next = MODE_RUN;
        end
      end
      default: begin
        mode_next = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master-slave latch
  // the master takes the head of the fifo each rise phase in run mode; when the fifo is
  // empty it holds, so the output repeats the last word instead of glitching
  logic [WIDTH-1:0] master_reg;
  logic [WIDTH-1:0] master_next;
  logic             master_new_reg;
  logic             master_new_next;
  logic [WIDTH-1:0] slave_reg;
  logic [WIDTH-1:0] slave_next;
  logic             update_reg;
  logic             update_next;
  logic             take;

  // sleep stalls the stream, so back-pressure reaches the source
  assign take          = rise_en && out_bus.valid && (mode_reg == MODE_RUN);
  assign out_bus.ready = take;

  always_comb begin
    master_next     = master_reg;
    master_new_next = master_new_reg;
    slave_next      = slave_reg;
    update_next     = 1'b0;
    if (take) begin
      master_next     = out_bus.data;
      master_new_next = 1'b1;
    end else if (fall_en) begin
      master_new_next = 1'b0;
      slave_next      = master_reg;
      update_next     = master_new_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      master_reg     <= CODE_ZERO;
      master_new_reg <= 1'b0;
      slave_reg      <= CODE_ZERO;
      update_reg     <= 1'b0;
    end else begin
      master_reg     <= master_next;
      master_new_reg <= master_new_next;
      slave_reg      <= slave_next;
      update_reg     <= update_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered ready
  // a shadow of the fifo fill level lets ready leave from a flip-flop and
  // stay exact; a delayed copy of the fifo flag would lose a word when full
  localparam int unsigned LW = $clog2(DEPTH) + 1;
  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;
  logic          ready_reg;
  logic          ready_next;
  logic          push_in;

  assign push_in = in_bus.valid && in_bus.ready;

  always_comb begin
    level_next = level_reg;
    if (push_in && !take) begin
      level_next = level_reg + 1'b1;
    end else if (take && !push_in) begin
      level_next = level_reg - 1'b1;
    end
    ready_next = (level_next != LW'(DEPTH));
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      level_reg <= level_next;
      ready_reg <= ready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output steering and reference select
  logic [WIDTH:0] true_next;
  logic [WIDTH:0] comp_next;
  logic [WIDTH:0] true_reg;
  logic [WIDTH:0] comp_reg;
  logic           bandgap_reg;
  logic           reference_voltage_pin_reg;

  // code scales to code/4095 of full scale; true plus complement is constant except in sleep, where both are zero
  always_comb begin
    true_next = {1'b0, slave_reg};
    comp_next = CURRENT_FULL - {1'b0, slave_reg};
    if (mode_reg == MODE_SLEEP) begin
      true_next = '0;
      comp_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      true_reg    <= '0;
      comp_reg    <= '0;
      bandgap_reg <= 1'b1;
      reference_voltage_pin_reg   <= 1'b0;
    end else begin
      true_reg    <= true_next;
      comp_reg    <= comp_next;
      bandgap_reg <= (ref_s2_reg == REF_INTERNAL);
      reference_voltage_pin_reg   <= (ref_s2_reg == REF_EXTERNAL);
    end
  end

  // one-hot mode: bit 1 is the sleep state, so sleep leaves from a flop
  assign sample_ready_o                   = ready_reg;
  assign output_code_o                    = slave_reg;
  assign true_current_output_o            = true_reg;
  assign complement_current_o             = comp_reg;
  assign output_update_o                  = update_reg;
  assign sleep_active_o                   = mode_reg[1];
  assign bandgap_enable_o                 = bandgap_reg;
  assign reference_voltage_pin_is_input_o = reference_voltage_pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  slave_follows_master_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (take) |=> ##1 (slave_reg == $past(out_bus.data, 2)))
    else $error("slave did not take captured word");

  master_capture_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    take |=> (master_reg == $past(out_bus.data)))
    else $error("master missed word");

  sleep_enter_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (sleep_level && mode_reg == MODE_RUN) |=> (mode_reg == MODE_SLEEP))
    else $error("sleep not entered");

  sleep_stalls_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (mode_reg == MODE_SLEEP) |-> !take)
    else $error("sample taken in sleep");

  sleep_quiet_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (mode_reg == MODE_SLEEP) |=> (true_reg == '0 && comp_reg == '0))
    else $error("current flows in sleep");

  pulldown_run_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (!driven_s2_reg)[*2] |=> (mode_reg == MODE_RUN))
    else $error("floating sleep pin did not run");

  bandgap_sel_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (ref_s2_reg == REF_INTERNAL) |=> bandgap_reg && !reference_voltage_pin_reg)
    else $error("internal reference not selected");

  extref_sel_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (ref_s2_reg == REF_EXTERNAL) |=> !bandgap_reg && reference_voltage_pin_reg)
    else $error("external reference not selected");

  // the first edge after reset still shows the reset currents, not a split
  steer_sum_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (!$past(rst_i) && mode_reg == MODE_RUN && $past(mode_reg) == MODE_RUN)
      |-> (true_reg + comp_reg == CURRENT_FULL))
    else $error("output currents do not sum to full scale");

  full_code_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    (slave_reg == CODE_FULL && mode_reg == MODE_RUN && mode_next == MODE_RUN)
      |=> (comp_reg == '0))
    else $error("full code leaks complement");

  ready_mirror_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    ready_reg == in_bus.ready)
    else $error("registered ready disagrees with fifo");
endmodule

// ==== tb/sample_source_model.sv ====
// partner model: a sample source that offers words on valid/ready
`timescale 1ns/1ps
module sample_source_model (
  // clock
  input  wire logic   sys_clk_i,
  // stream towards the block
  input  wire logic   ready_i,
  output logic [11:0] data_o,
  output logic        valid_o
);
  logic [11:0] words[$];
  int          gap;
  int          idle;
  logic        taken;
  initial begin
    valid_o = 1'b0;
    data_o  = 12'h000;
    gap     = 0;
    idle    = 0;
    forever begin
      @(posedge sys_clk_i);
      taken = valid_o && ready_i;
      #1;
      if (taken) begin
        words.delete(0);
        idle = gap;
      end
      // an offered word is held until the edge that takes it
      if (!valid_o || taken) begin
        if (idle == 0 && words.size() > 0) begin
          valid_o = 1'b1;
          data_o  = words[0];
        end else begin
          if (idle > 0) idle--;
          valid_o = 1'b0;
          // idle bus inverts data each cycle, so the stale word returns every second idle cycle
          data_o  = ~data_o;
        end
      end
    end
  end
endmodule

// ==== tb/dac_input_latch_control_tb.sv ====
// self-checking bench for the converter front end
`timescale 1ns/1ps
module dac_input_latch_control_tb;
  import dac_latch_pkg::*;
  logic        sys_clk_i;
  logic        rst_i;
  logic [11:0] sample_data_i;
  logic        sample_valid_i;
  logic        sample_ready_o;
  logic        sleep_request_pin_i;
  logic        sleep_pin_driven_i;
  logic        ref_select_i;
  logic [11:0] output_code_o;
  logic [12:0] true_current_output_o;
  logic [12:0] complement_current_o;
  logic        output_update_o;
  logic        sleep_active_o;
  logic        bandgap_enable_o;
  logic        reference_voltage_pin_is_input_o;
  logic [11:0] got[$];
  int          bad_count;
  int          checked;
  int          cycles;
  //////////////////////////////////////////////////////////////////////////
  dac_input_latch_control dac_input_latch_control_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .sample_data_i(sample_data_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o),
    .sleep_request_pin_i(sleep_request_pin_i),
    .sleep_pin_driven_i(sleep_pin_driven_i), .ref_select_i(ref_select_i),
    .output_code_o(output_code_o),
    .true_current_output_o(true_current_output_o),
    .complement_current_o(complement_current_o),
    .output_update_o(output_update_o), .sleep_active_o(sleep_active_o),
    .bandgap_enable_o(bandgap_enable_o),
    .reference_voltage_pin_is_input_o(reference_voltage_pin_is_input_o));
  sample_source_model sample_source_model_inst (
    .sys_clk_i(sys_clk_i), .ready_i(sample_ready_o),
    .data_o(sample_data_i), .valid_o(sample_valid_i));
  //////////////////////////////////////////////////////////////////////////
  // 50% duty, 100 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (output_update_o === 1'b1) got.push_back(output_code_o);
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [12:0] val, input logic [12:0] exp,
                       input string what);
    checked++;
    if (val !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, val, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // bounded wait for n captured words
  task automatic wait_words(input int n);
    for (int i = 0; i < 400 && got.size() < n; i++) tick(1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({1'b0, output_code_o}, 13'h0000, "code");
    check(true_current_output_o, 13'h0000, "true");
    check(complement_current_o, CURRENT_FULL, "comp");
    check({12'h000, sleep_active_o}, 13'h0000, "sleep");
    check({12'h000, bandgap_enable_o}, 13'h0001, "bandgap");
    check({12'h000, sample_ready_o}, 13'h0001, "ready");
  endtask
  // each code reaches the latch and splits the current as coded
  task automatic t_codes();
    logic [11:0] codes[4];
    codes = '{CODE_ZERO, CODE_MID, CODE_FULL, 12'h001};
    sample_source_model_inst.gap = 2;
    foreach (codes[i]) begin
      got.delete();
      sample_source_model_inst.words.push_back(codes[i]);
      wait_words(1);
      tick(2);
      check({1'b0, got[0]}, {1'b0, codes[i]}, "latched");
      check({1'b0, output_code_o}, {1'b0, codes[i]}, "code");
      check(true_current_output_o, {1'b0, codes[i]}, "true");
      check(complement_current_o, CURRENT_FULL - {1'b0, codes[i]},
            "comp");
    end
    sample_source_model_inst.gap = 0;
  endtask
  // sleep holds the fifo, which fills and refuses, then drains in order
  task automatic t_fill();
    sleep_request_pin_i = 1'b1;
    tick(6);
    check({12'h000, sleep_active_o}, 13'h0001, "sleep");
    check(true_current_output_o, 13'h0000, "sleep true");
    got.delete();
    for (int i = 0; i < 17; i++) begin
      sample_source_model_inst.words.push_back(12'h100 + 12'(i));
    end
    tick(40);
    check({12'h000, sample_ready_o}, 13'h0000, "full");
    check(13'(got.size()), 13'h0000, "no drain");
    sleep_request_pin_i = 1'b0;
    wait_words(17);
    tick(2);
    check(13'(got.size()), 13'h0011, "count");
    foreach (got[i]) begin
      check({1'b0, got[i]}, 13'h0100 + 13'(i), "order");
    end
    check({12'h000, sleep_active_o}, 13'h0000, "run");
  endtask
  // a floating sleep pin reads low through the pull-down
  task automatic t_float();
    sleep_pin_driven_i  = 1'b0;
    sleep_request_pin_i = 1'b1;
    tick(6);
    check({12'h000, sleep_active_o}, 13'h0000, "float");
    got.delete();
    sample_source_model_inst.words.push_back(12'h5a5);
    wait_words(1);
    tick(2);
    check(true_current_output_o, 13'h05a5, "float true");
    sleep_pin_driven_i  = 1'b1;
    sleep_request_pin_i = 1'b0;
  endtask
  task automatic t_ref();
    ref_select_i = REF_EXTERNAL;
    tick(6);
    check({12'h000, bandgap_enable_o}, 13'h0000, "ext bg");
    check({12'h000, reference_voltage_pin_is_input_o}, 13'h0001,
          "ext pin");
    ref_select_i = REF_INTERNAL;
    tick(6);
    check({12'h000, bandgap_enable_o}, 13'h0001, "int bg");
    check({12'h000, reference_voltage_pin_is_input_o}, 13'h0000,
          "int pin");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count           = 0;
    checked             = 0;
    cycles              = 0;
    rst_i               = 1'b1;
    sleep_request_pin_i = 1'b0;
    sleep_pin_driven_i  = 1'b1;
    ref_select_i        = REF_INTERNAL;
    tick(3);
    rst_i = 1'b0;
    tick(3);
    t_reset();
    t_codes();
    t_fill();
    t_float();
    t_ref();
    end_sim();
  end
endmodule
